// >>> logic/embm_defs.svh
// constants of the embedded block memory
`ifndef EMBM_DEFS_SVH
`define EMBM_DEFS_SVH
`define EMBM_ARRAY_BITS 18432
`define EMBM_ROWS 512
`define EMBM_ROW_W 9
`define EMBM_WORD_W 36
`define EMBM_ADDR_W 14
`define EMBM_OFF_W 6
`define EMBM_CS_W 3
`define EMBM_CS_DECODE 3'h0
`define EMBM_RST_DATA 36'h0
`endif

// >>> logic/embm_pkg.sv
// types and address mapping of the embedded block memory
package embm_pkg;
	// ****************************************
	// port width modes
	// ****************************************
	typedef enum logic [2:0] {
		width_1 = 3'h0,
		width_2 = 3'h1,
		width_4 = 3'h2,
		width_9 = 3'h3,
		width_18 = 3'h4,
		width_36 = 3'h5
	} embm_width_e;

	typedef struct packed {
		logic [8:0] row;
		logic [5:0] off;
	} embm_loc_s;

	// ****************************************
	// helpers shared by both ports
	// ****************************************
	// narrow modes pack 32 bits per row, wide modes use all 36
	function automatic embm_loc_s map_addr(input embm_width_e w,
		input logic [13:0] a);
		embm_loc_s l;
		l = '0;
		case (w)
			width_1: l = '{a[13:5], {1'b0, a[4:0]}};
			width_2: l = '{a[12:4], {1'b0, a[3:0], 1'b0}};
			width_4: l = '{a[11:3], {1'b0, a[2:0], 2'h0}};
			width_9: l = '{a[10:2], 6'(a[1:0] * 4'h9)};
			width_18: l = '{a[9:1], a[0] ? 6'h12 : 6'h00};
			default: l = '{a[8:0], 6'h00};
		endcase
		return l;
	endfunction : map_addr

	function automatic logic [35:0] width_mask(input embm_width_e w);
		logic [35:0] m;
		m = '0;
		case (w)
			width_1: m = 36'h000000001;
			width_2: m = 36'h000000003;
			width_4: m = 36'h00000000f;
			width_9: m = 36'h0000001ff;
			width_18: m = 36'h00003ffff;
			default: m = 36'hfffffffff;
		endcase
		return m;
	endfunction : width_mask
endpackage : embm_pkg

// >>> logic/embm_mem_if.sv
// array-side carrier between port logic and storage
`timescale 1ns/1ns
interface embm_mem_if;
	logic rd_en;
	logic rd_clr;
	logic [8:0] rd_row;
	logic [5:0] rd_off;
	logic [35:0] rd_mask;
	logic [35:0] rd_data;
	logic wr_en;
	logic [8:0] wr_row;
	logic [35:0] wr_data;
	logic [35:0] wr_mask;
	modport ports (output rd_en, rd_clr, rd_row, rd_off, rd_mask,
		output wr_en, wr_row, wr_data, wr_mask, input rd_data);
	modport array (input rd_en, rd_clr, rd_row, rd_off, rd_mask,
		input wr_en, wr_row, wr_data, wr_mask, output rd_data);
endinterface : embm_mem_if

// >>> logic/embm_array.sv
// storage array of 512 rows by 36 bits with registered read
`timescale 1ns/1ns
`include "embm_defs.svh"
module embm_array #(
	parameter logic [`EMBM_ARRAY_BITS-1:0] INIT_IMAGE = '0
) (
	input wire logic clk_i,
	input wire logic arst_i,
	embm_mem_if.array m
);
	logic [`EMBM_WORD_W-1:0] mem [`EMBM_ROWS];
	logic [`EMBM_WORD_W-1:0] rdata;
	logic [`EMBM_WORD_W-1:0] next_rdata;

	// ****************************************
	// preload, zero image unless given
	// ****************************************
	initial begin
		for (int i = 0; i < `EMBM_ROWS; i++) begin
			mem[i] = INIT_IMAGE[i*`EMBM_WORD_W +: `EMBM_WORD_W];
		end
	end

	// array write: never touched by any reset
	// plain always, since the preload above also assigns the array
	always @(posedge clk_i) begin
		if (m.wr_en) begin
			mem[m.wr_row] <= (mem[m.wr_row] & ~m.wr_mask) |
				(m.wr_data & m.wr_mask);
		end
	end

	// read lane; old word on same-row write, no write-through
	always_comb begin
		next_rdata = rdata;
		if (m.rd_clr) begin
			next_rdata = `EMBM_RST_DATA;
		end else if (m.rd_en) begin
			next_rdata = (mem[m.rd_row] >> m.rd_off) & m.rd_mask;
		end
	end

	// read register holds only port state, so reset may clear it
	always_ff @(posedge clk_i or posedge arst_i) begin
		if (arst_i) begin
			rdata <= `EMBM_RST_DATA;
		end else begin
			rdata <= next_rdata;
		end
	end

	assign m.rd_data = rdata;
endmodule : embm_array

// >>> logic/embm_block.sv
// embedded block memory: pseudo dual port ram or rom
// Operation
// - storage is exactly 18432 bits
// - read depths 16K down to 512
// - read widths 1 to 36, default 36
// - write depths 16K down to 512
// - rom read address is taken at the array edge together with the access
// - optional output register, unregistered default
// - reset clears input and output registers
// - reset leaves stored contents intact
// - port reset asynchronous or synchronous, async default; rst_i and global set reset always async
// - global set reset participation selectable
// - chip select acts as top address
// - port answers only on fixed decode
// - larger memories cascade, small fit one
// - rom contents preloaded from image
// - normal mode only, no write-through
// - write data and addresses registered
// - rising edges, enables active high
`timescale 1ns/1ns
`include "embm_defs.svh"
module embm_block #(
	parameter logic [`EMBM_ARRAY_BITS-1:0] INIT_IMAGE = '0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic global_set_reset_i,
	input wire logic port_rst_i,
	input wire logic cfg_rom_i,
	input wire logic [2:0] cfg_rd_width_i,
	input wire logic [2:0] cfg_wr_width_i,
	input wire logic cfg_registered_output_i,
	input wire logic cfg_sync_rst_i,
	input wire logic cfg_gsr_en_i,
	input wire logic read_clk_en_i,
	input wire logic [`EMBM_CS_W-1:0] rd_cs_i,
	input wire logic [`EMBM_ADDR_W-1:0] rd_addr_i,
	input wire logic write_clk_en_i,
	input wire logic wr_en_i,
	input wire logic [`EMBM_CS_W-1:0] wr_cs_i,
	input wire logic [`EMBM_ADDR_W-1:0] wr_addr_i,
	input wire logic [`EMBM_WORD_W-1:0] wr_data_a_i,
	output logic [`EMBM_WORD_W-1:0] rd_data_a_o
);
	// ****************************************
	// reset routing
	// ****************************************
	logic arst;
	logic sclr;
	// config is static, so gating the async path cannot glitch
	assign arst = rst_i | (global_set_reset_i & cfg_gsr_en_i) |
		(port_rst_i & ~cfg_sync_rst_i);
	assign sclr = port_rst_i & cfg_sync_rst_i;

	embm_pkg::embm_width_e rd_w;
	embm_pkg::embm_width_e wr_w;
	assign rd_w = embm_pkg::embm_width_e'(cfg_rd_width_i);
	assign wr_w = embm_pkg::embm_width_e'(cfg_wr_width_i);

	// ****************************************
	// chip select decode
	// ****************************************
	logic rd_hit;
	logic wr_hit;
	// cs forms the top address bits of a cascade of up to eight
	assign rd_hit = (rd_cs_i == `EMBM_CS_DECODE);
	assign wr_hit = (wr_cs_i == `EMBM_CS_DECODE);

	embm_pkg::embm_loc_s rd_loc;
	embm_pkg::embm_loc_s wr_loc;
	assign rd_loc = embm_pkg::map_addr(rd_w, rd_addr_i);
	assign wr_loc = embm_pkg::map_addr(wr_w, wr_addr_i);

	embm_mem_if m ();

	// ****************************************
	// write input registers
	// ****************************************
	logic wr_en_q;
	logic [8:0] wr_row_q;
	logic [35:0] wr_data_q;
	logic [35:0] wr_mask_q;
	logic next_wr_en_q;
	logic [8:0] next_wr_row_q;
	logic [35:0] next_wr_data_q;
	logic [35:0] next_wr_mask_q;

	// rom has no write path; writes land one edge after capture
	always_comb begin
		next_wr_en_q = 1'b0;
		next_wr_row_q = wr_row_q;
		next_wr_data_q = wr_data_q;
		next_wr_mask_q = wr_mask_q;
		if (sclr) begin
			next_wr_row_q = '0;
			next_wr_data_q = '0;
			next_wr_mask_q = '0;
		end else if (write_clk_en_i) begin
			next_wr_en_q = wr_en_i & wr_hit & ~cfg_rom_i;
			next_wr_row_q = wr_loc.row;
			next_wr_data_q = (wr_data_a_i & embm_pkg::width_mask(wr_w))
				<< wr_loc.off;
			next_wr_mask_q = embm_pkg::width_mask(wr_w) << wr_loc.off;
		end
	end

	always_ff @(posedge clk_i or posedge arst) begin
		if (arst) begin
			wr_en_q <= 1'b0;
			wr_row_q <= '0;
			wr_data_q <= '0;
			wr_mask_q <= '0;
		end else begin
			wr_en_q <= next_wr_en_q;
			wr_row_q <= next_wr_row_q;
			wr_data_q <= next_wr_data_q;
			wr_mask_q <= next_wr_mask_q;
		end
	end

	// ****************************************
	// array hookup
	// ****************************************
	// read address is taken at the array edge with the enable
	assign m.rd_en = read_clk_en_i;
	assign m.rd_clr = sclr | (read_clk_en_i & ~rd_hit);
	assign m.rd_row = rd_loc.row;
	assign m.rd_off = rd_loc.off;
	assign m.rd_mask = embm_pkg::width_mask(rd_w);
	assign m.wr_en = wr_en_q;
	assign m.wr_row = wr_row_q;
	assign m.wr_data = wr_data_q;
	assign m.wr_mask = wr_mask_q;

	embm_array #(
		.INIT_IMAGE(INIT_IMAGE)
	) u_array (
		.clk_i(clk_i),
		.arst_i(arst),
		.m(m)
	);

	// ****************************************
	// optional output register
	// ****************************************
	logic [35:0] out_q;
	logic [35:0] next_out_q;

	// holds while the read enable is low, like the array stage
	always_comb begin
		next_out_q = out_q;
		if (sclr) begin
			next_out_q = `EMBM_RST_DATA;
		end else if (read_clk_en_i) begin
			next_out_q = m.rd_data;
		end
	end

	always_ff @(posedge clk_i or posedge arst) begin
		if (arst) begin
			out_q <= `EMBM_RST_DATA;
		end else begin
			out_q <= next_out_q;
		end
	end

	// both sources are flops; the select is a static setting
	assign rd_data_a_o = cfg_registered_output_i ? out_q : m.rd_data;

	// ****************************************
	// checks
	// ****************************************
	property p_rom_no_write;
		@(posedge clk_i) disable iff (arst)
		cfg_rom_i |=> !wr_en_q;
	endproperty
	a_rom_no_write: assert property (p_rom_no_write)
		else $error("write reached array in rom mode");

	property p_wr_capture;
		@(posedge clk_i) disable iff (arst)
		(write_clk_en_i && wr_en_i && wr_hit && !cfg_rom_i && !sclr)
			|=> wr_en_q && wr_row_q == $past(wr_loc.row);
	endproperty
	a_wr_capture: assert property (p_wr_capture)
		else $error("write not captured in input register");

	property p_wr_cs;
		@(posedge clk_i) disable iff (arst)
		!wr_hit |=> !wr_en_q;
	endproperty
	a_wr_cs: assert property (p_wr_cs)
		else $error("write taken on foreign chip select");

	property p_wr_ce;
		@(posedge clk_i) disable iff (arst)
		!(write_clk_en_i && wr_en_i) |=> !wr_en_q;
	endproperty
	a_wr_ce: assert property (p_wr_ce)
		else $error("write without clock and write enable");

	property p_out_hold;
		@(posedge clk_i) disable iff (arst)
		(!read_clk_en_i && !sclr) |=> $stable(out_q);
	endproperty
	a_out_hold: assert property (p_out_hold)
		else $error("output register moved without enable");

	property p_out_follow;
		@(posedge clk_i) disable iff (arst)
		(read_clk_en_i && !sclr) |=> out_q == $past(m.rd_data);
	endproperty
	a_out_follow: assert property (p_out_follow)
		else $error("output register missed array data");

	property p_sync_clr;
		@(posedge clk_i) disable iff (arst)
		sclr |=> out_q == `EMBM_RST_DATA && !wr_en_q &&
			m.rd_data == `EMBM_RST_DATA;
	endproperty
	a_sync_clr: assert property (p_sync_clr)
		else $error("synchronous reset left a port register set");

	property p_rd_desel;
		@(posedge clk_i) disable iff (arst)
		(read_clk_en_i && !rd_hit) ##1 read_clk_en_i
			|=> out_q == `EMBM_RST_DATA;
	endproperty
	a_rd_desel: assert property (p_rd_desel)
		else $error("deselected read produced data");
endmodule : embm_block

// >>> tb/embm_user_model.sv
// fabric-side model driving the read and write ports
`timescale 1ns/1ns
module embm_user_model (
	input wire logic clk_i,
	input wire logic reg_out_i,
	input wire logic [35:0] rd_data_a_i,
	output logic read_clk_en_o,
	output logic [2:0] rd_cs_o,
	output logic [13:0] rd_addr_o,
	output logic write_clk_en_o,
	output logic wr_en_o,
	output logic [2:0] wr_cs_o,
	output logic [13:0] wr_addr_o,
	output logic [35:0] wr_data_a_o
);
	// idle ports: enables low, lines parked
	initial begin
		read_clk_en_o = 1'b0;
		rd_cs_o = 3'h0;
		rd_addr_o = 14'h0;
		write_clk_en_o = 1'b0;
		wr_en_o = 1'b0;
		wr_cs_o = 3'h0;
		wr_addr_o = 14'h0;
		wr_data_a_o = 36'h0;
	end

	// one write, held over its taking edge only
	task automatic wr(input logic [2:0] cs, input logic [13:0] a,
		input logic [35:0] d);
		@(posedge clk_i) #1;
		write_clk_en_o = 1'b1;
		wr_en_o = 1'b1;
		wr_cs_o = cs;
		wr_addr_o = a;
		wr_data_a_o = d;
		@(posedge clk_i) #1;
		write_clk_en_o = 1'b0;
		wr_en_o = 1'b0;
		// released lines change, so a stale value cannot pass
		wr_addr_o = ~a;
		wr_data_a_o = ~d;
	endtask : wr

	// read; p is seen after the first edge, q when data is due
	task automatic rd(input logic [2:0] cs, input logic [13:0] a,
		output logic [35:0] p, output logic [35:0] q);
		@(posedge clk_i) #1;
		read_clk_en_o = 1'b1;
		rd_cs_o = cs;
		rd_addr_o = a;
		@(posedge clk_i) #1;
		p = rd_data_a_i;
		if (reg_out_i) begin
			@(posedge clk_i) #1;
		end
		q = rd_data_a_i;
		read_clk_en_o = 1'b0;
		rd_addr_o = ~a;
	endtask : rd
endmodule : embm_user_model

// >>> tb/embm_block_tb_top.sv
// self-checking bench of the embedded block memory
`timescale 1ns/1ns
module embm_block_tb_top;
	localparam logic [18431:0] IMG = 18432'(36'h123456789) << 36;
	localparam logic [35:0] V = 36'habcdef012;
	localparam logic [17:0] D18 = 18'h3c0a5;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic global_set_reset = 1'b0;
	logic prst = 1'b0;
	logic rom = 1'b0;
	logic [2:0] rdw = 3'h5;
	logic [2:0] wrw = 3'h5;
	logic regout = 1'b0;
	logic syncr = 1'b0;
	logic gsr_en = 1'b1;
	logic rce, wce, wen;
	logic [2:0] rcs, wcs;
	logic [13:0] ra, wa;
	logic [35:0] wd, rdat, p, q;
	int fails = 0;
	int compares = 0;

	// ****************************************
	// clock, design and fabric model
	// ****************************************
	always #50 clk_i = ~clk_i;

	embm_block #(.INIT_IMAGE(IMG)) i_embm_block (.clk_i(clk_i),
		.rst_i(rst_i), .global_set_reset_i(global_set_reset), .port_rst_i(prst),
		.cfg_rom_i(rom), .cfg_rd_width_i(rdw), .cfg_wr_width_i(wrw),
		.cfg_registered_output_i(regout), .cfg_sync_rst_i(syncr),
		.cfg_gsr_en_i(gsr_en), .read_clk_en_i(rce), .rd_cs_i(rcs),
		.rd_addr_i(ra), .write_clk_en_i(wce), .wr_en_i(wen),
		.wr_cs_i(wcs), .wr_addr_i(wa), .wr_data_a_i(wd),
		.rd_data_a_o(rdat));

	embm_user_model i_embm_user_model (.clk_i(clk_i),
		.reg_out_i(regout), .rd_data_a_i(rdat), .read_clk_en_o(rce),
		.rd_cs_o(rcs), .rd_addr_o(ra), .write_clk_en_o(wce),
		.wr_en_o(wen), .wr_cs_o(wcs), .wr_addr_o(wa),
		.wr_data_a_o(wd));

	// ****************************************
	// compare and closing
	// ****************************************
	task automatic chk(input string n, input logic [35:0] e,
		input logic [35:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic test_done();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done

	// hang guard, far beyond the sequence length
	initial begin
		#2000000;
		fails++;
		test_done();
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (20) @(posedge clk_i);
		#1 rst_i = 1'b0;
		chk("out after reset", 36'h0, rdat);
		i_embm_user_model.rd(3'h0, 14'h1, p, q);
		chk("preloaded row", 36'h123456789, q);
		i_embm_user_model.rd(3'h0, 14'h2, p, q);
		chk("blank row", 36'h0, q);
		i_embm_user_model.wr(3'h0, 14'h5, V);
		i_embm_user_model.rd(3'h0, 14'h5, p, q);
		chk("write readback", V, q);
		// foreign chip selects on either port
		i_embm_user_model.wr(3'h2, 14'h6, V);
		i_embm_user_model.rd(3'h0, 14'h6, p, q);
		chk("deselected write", 36'h0, q);
		i_embm_user_model.rd(3'h1, 14'h5, p, q);
		chk("deselected read", 36'h0, q);
		// one row seen one bit at a time
		i_embm_user_model.wr(3'h0, 14'h0, 36'h0000000f5);
		rdw = 3'h0;
		for (int i = 0; i < 8; i++) begin
			i_embm_user_model.rd(3'h0, 14'(i), p, q);
			chk("x1 lane", {35'h0, 1'((8'hf5 >> i) & 8'h1)}, q);
		end
		// half-row write: upper data bits dropped, upper lane of row 3
		wrw = 3'h4;
		i_embm_user_model.wr(3'h0, 14'h7, {18'h2a5a5, D18});
		wrw = 3'h5;
		rdw = 3'h5;
		i_embm_user_model.rd(3'h0, 14'h3, p, q);
		chk("x18 write", {D18, 18'h0}, q);
		// same row through the x18, x9, x4 and x2 read widths
		rdw = 3'h4;
		i_embm_user_model.rd(3'h0, 14'h7, p, q);
		chk("x18 lane", {18'h0, D18}, q);
		rdw = 3'h3;
		i_embm_user_model.rd(3'h0, 14'he, p, q);
		chk("x9 lane 2", {27'h0, D18[8:0]}, q);
		i_embm_user_model.rd(3'h0, 14'hf, p, q);
		chk("x9 lane 3", {27'h0, D18[17:9]}, q);
		rdw = 3'h2;
		i_embm_user_model.rd(3'h0, 14'h1d, p, q);
		chk("x4 lane", {32'h0, D18[5:2]}, q);
		rdw = 3'h1;
		i_embm_user_model.rd(3'h0, 14'h39, p, q);
		chk("x2 lane", {34'h0, D18[1:0]}, q);
		rdw = 3'h5;
		// output stage: first edge still shows earlier data
		regout = 1'b1;
		i_embm_user_model.rd(3'h0, 14'h1, p, q);
		i_embm_user_model.rd(3'h0, 14'h5, p, q);
		chk("reg stage lag", 36'h123456789, p);
		chk("reg stage data", V, q);
		i_embm_user_model.rd(3'h1, 14'h5, p, q);
		chk("reg deselected read", 36'h0, q);
		// rom ignores writes
		rom = 1'b1;
		i_embm_user_model.wr(3'h0, 14'h5, 36'h0);
		i_embm_user_model.rd(3'h0, 14'h5, p, q);
		chk("rom write", V, q);
		rom = 1'b0;
		// sync port reset clears output, keeps contents
		syncr = 1'b1;
		prst = 1'b1;
		#10;
		chk("sync before edge", V, rdat);
		@(posedge clk_i) #1;
		chk("sync cleared", 36'h0, rdat);
		prst = 1'b0;
		i_embm_user_model.rd(3'h0, 14'h5, p, q);
		chk("kept contents", V, q);
		// global reset ignored when disabled, acts when enabled
		gsr_en = 1'b0;
		global_set_reset = 1'b1;
		#10;
		chk("gsr off", V, rdat);
		@(posedge clk_i) #1;
		gsr_en = 1'b1;
		#10;
		chk("gsr on", 36'h0, rdat);
		@(posedge clk_i) #1;
		global_set_reset = 1'b0;
		syncr = 1'b0;
		i_embm_user_model.rd(3'h0, 14'h5, p, q);
		chk("after global reset", V, q);
		// async port reset clears between edges
		prst = 1'b1;
		#10;
		chk("async port reset", 36'h0, rdat);
		@(posedge clk_i) #1;
		prst = 1'b0;
		test_done();
	end
endmodule : embm_block_tb_top
